// file: hdl/sled_ctrl.sv
// Status and identification LED controller
`timescale 1ns/1ps
module sled_ctrl
    import sled_pkg::*;
(
    input  wire logic              CORE_CLK,      // 125 MHz standby clock
    input  wire logic              RST_N,         // Async reset, AC power-up only
    input  wire logic              ID_BUTTON,     // Front-panel identify button, high when pressed
    input  wire logic              ID_REMOTE_ON,  // One-cycle pulse: chassis identify start
    input  wire logic              ID_REMOTE_OFF, // One-cycle pulse: chassis identify stop
    input  wire sled_pkg::sled_boot_t BOOT_STAGE, // Controller boot progress
    input  wire logic              BOOT_ERROR,    // Controller boot reported an error
    input  wire sled_pkg::sled_cond_t COND,       // Reported system conditions
    output logic                   ID_LED,        // On-board blue ID LED
    output logic                   FP_ID_LED,     // Front-panel ID LED
    output sled_pkg::sled_bicolor_t HEALTH_LED,   // On-board health LED
    output sled_pkg::sled_bicolor_t FP_HEALTH_LED // Front-panel health LED
);
    import sled_pkg::*;

    logic [CNT_W-1:0] cnt_1hz;
    logic [CNT_W-1:0] cnt_3hz;
    logic             ph_1hz;
    logic             ph_3hz;
    logic             button_q;
    logic             id_steady;
    logic             id_blink;
    logic             seen_powerup;
    sled_health_t     next_health;
    logic             next_id;
    sled_bicolor_t    next_bicolor;

    function automatic logic [CNT_W-1:0] wrap_inc(input logic [CNT_W-1:0] c, input int unsigned half);
        wrap_inc = (c == CNT_W'(half - 1)) ? '0 : c + 1'b1;
    endfunction : wrap_inc

    // Blink phase generators; 1 Hz also paces the slow identify blink
    always_ff @(posedge CORE_CLK or negedge RST_N) begin
        if (!RST_N) begin
            cnt_1hz <= '0;
            ph_1hz  <= 1'b0;
        end else begin
            cnt_1hz <= wrap_inc(cnt_1hz, HALF_1HZ_CYC);
            if (cnt_1hz == CNT_W'(HALF_1HZ_CYC - 1)) begin
                ph_1hz <= ~ph_1hz;
            end
        end
    end

    always_ff @(posedge CORE_CLK or negedge RST_N) begin
        if (!RST_N) begin
            cnt_3hz <= '0;
            ph_3hz  <= 1'b0;
        end else begin
            cnt_3hz <= wrap_inc(cnt_3hz, HALF_3HZ_CYC);
            if (cnt_3hz == CNT_W'(HALF_3HZ_CYC - 1)) begin
                ph_3hz <= ~ph_3hz;
            end
        end
    end

    // Button is level; only the press edge toggles, so a held button acts once
    always_ff @(posedge CORE_CLK or negedge RST_N) begin
        if (!RST_N) begin
            button_q  <= 1'b0;
            id_steady <= 1'b0;
        end else begin
            button_q <= ID_BUTTON;
            if (ID_BUTTON && !button_q) begin
                id_steady <= ~id_steady;
            end
        end
    end

    // Remote identify; start beats stop when both arrive together
    always_ff @(posedge CORE_CLK or negedge RST_N) begin
        if (!RST_N) begin
            id_blink <= 1'b0;
        end else if (ID_REMOTE_ON) begin
            id_blink <= 1'b1;
        end else if (ID_REMOTE_OFF) begin
            id_blink <= 1'b0;
        end
    end

    // One cycle of steady amber after AC power-up, then boot display takes over
    always_ff @(posedge CORE_CLK or negedge RST_N) begin
        if (!RST_N) begin
            seen_powerup <= 1'b0;
        end else begin
            seen_powerup <= 1'b1;
        end
    end

    // Severity priority; no DC-off input exists, so host power state cannot disturb it
    always_comb begin
        if (!seen_powerup || COND.fatal) begin
            next_health = SLED_SOLID_AMBER;
        end else if (COND.noncritical) begin
            next_health = SLED_BLINK_AMBER;
        end else if (COND.degraded || COND.wdt_reset || COND.pu_cfg_err || COND.hsc_degraded
                     || BOOT_STAGE != SLED_BOOT_DONE || BOOT_ERROR) begin
            next_health = SLED_BLINK_GREEN;
        end else begin
            next_health = SLED_SOLID_GREEN;
        end
    end

    always_comb begin
        case (next_health)
            SLED_SOLID_GREEN: next_bicolor = '{green: 1'b1, amber: 1'b0};
            SLED_BLINK_GREEN: next_bicolor = '{green: ph_1hz, amber: 1'b0};
            SLED_BLINK_AMBER: next_bicolor = '{green: 1'b0, amber: ph_1hz};
            SLED_SOLID_AMBER: next_bicolor = '{green: 1'b0, amber: 1'b1};
            default:          next_bicolor = '{green: 1'b0, amber: 1'b1};
        endcase
    end

    // Loader and OS boot stages override user identify so firmware progress stays visible
    always_comb begin
        case (BOOT_STAGE)
            SLED_BOOT_LOADER: next_id = ph_3hz;
            SLED_BOOT_OS:     next_id = 1'b1;
            SLED_BOOT_DONE:   next_id = id_blink ? ph_1hz : id_steady;
            default:          next_id = id_blink ? ph_1hz : id_steady;
        endcase
    end

    // Registered state persists while standby power is up
    always_ff @(posedge CORE_CLK or negedge RST_N) begin
        if (!RST_N) begin
            ID_LED        <= 1'b0;
            FP_ID_LED     <= 1'b0;
            HEALTH_LED    <= '{green: 1'b0, amber: 1'b1};
            FP_HEALTH_LED <= '{green: 1'b0, amber: 1'b1};
        end else begin
            ID_LED        <= next_id;
            FP_ID_LED     <= next_id;
            HEALTH_LED    <= next_bicolor;
            FP_HEALTH_LED <= next_bicolor;
        end
    end

    sequence press_s;
        ID_BUTTON && !button_q;
    endsequence

    chk_button_toggles: assert property (@(posedge CORE_CLK) disable iff (!RST_N)
        press_s |=> id_steady != $past(id_steady))
        else $error("button press did not toggle id");
    chk_remote_blink: assert property (@(posedge CORE_CLK) disable iff (!RST_N)
        ID_REMOTE_ON |=> id_blink)
        else $error("remote identify not latched");
    chk_id_mirror: assert property (@(posedge CORE_CLK) disable iff (!RST_N)
        ID_LED == FP_ID_LED)
        else $error("front id differs");
    chk_health_mirror: assert property (@(posedge CORE_CLK) disable iff (!RST_N)
        HEALTH_LED == FP_HEALTH_LED)
        else $error("front health differs");
    chk_never_both: assert property (@(posedge CORE_CLK) disable iff (!RST_N)
        !(HEALTH_LED.green && HEALTH_LED.amber))
        else $error("both colours lit");
    chk_fatal_amber: assert property (@(posedge CORE_CLK) disable iff (!RST_N)
        COND.fatal |=> HEALTH_LED.amber && !HEALTH_LED.green)
        else $error("fatal not steady amber");
    chk_alarm_amber: assert property (@(posedge CORE_CLK) disable iff (!RST_N)
        (seen_powerup && COND.noncritical && !COND.fatal) |=> !HEALTH_LED.green)
        else $error("alarm shows green");
    chk_green_only_ok: assert property (@(posedge CORE_CLK) disable iff (!RST_N)
        (seen_powerup && COND == '0 && BOOT_STAGE == SLED_BOOT_DONE && !BOOT_ERROR)
        |=> HEALTH_LED.green && !HEALTH_LED.amber)
        else $error("healthy not steady green");
    chk_degraded_green: assert property (@(posedge CORE_CLK) disable iff (!RST_N)
        (seen_powerup && !COND.fatal && !COND.noncritical && (COND.wdt_reset || COND.hsc_degraded))
        |=> !HEALTH_LED.amber && HEALTH_LED.green == $past(ph_1hz))
        else $error("degraded not blinking green");
    chk_os_id_on: assert property (@(posedge CORE_CLK) disable iff (!RST_N)
        BOOT_STAGE == SLED_BOOT_OS |=> ID_LED)
        else $error("id not on during os boot");

    sequence held_s;
        ID_BUTTON && button_q;
    endsequence

    // Held button, remote stop and power-up checks; blinking displays must follow the phase sampled one cycle earlier
    chk_held_button: assert property (@(posedge CORE_CLK) disable iff (!RST_N)
        held_s |=> id_steady == $past(id_steady))
        else $error("held button toggled id again");
    chk_remote_stop: assert property (@(posedge CORE_CLK) disable iff (!RST_N)
        (ID_REMOTE_OFF && !ID_REMOTE_ON) |=> !id_blink)
        else $error("remote identify not stopped");
    chk_powerup_amber: assert property (@(posedge CORE_CLK) disable iff (!RST_N)
        $rose(seen_powerup) |-> HEALTH_LED.amber && !HEALTH_LED.green)
        else $error("no steady amber at power-up");
    chk_boot_pending_green: assert property (@(posedge CORE_CLK) disable iff (!RST_N)
        (seen_powerup && COND == '0 && BOOT_STAGE != SLED_BOOT_DONE)
        |=> !HEALTH_LED.amber && HEALTH_LED.green == $past(ph_1hz))
        else $error("unfinished boot not blinking green");
    chk_degraded_blink: assert property (@(posedge CORE_CLK) disable iff (!RST_N)
        (seen_powerup && !COND.fatal && !COND.noncritical && COND.degraded)
        |=> !HEALTH_LED.amber && HEALTH_LED.green == $past(ph_1hz))
        else $error("degraded not blinking green");
    chk_loader_id_fast: assert property (@(posedge CORE_CLK) disable iff (!RST_N)
        BOOT_STAGE == SLED_BOOT_LOADER |=> ID_LED == $past(ph_3hz))
        else $error("id not on fast blink in loader");
    chk_os_health_blink: assert property (@(posedge CORE_CLK) disable iff (!RST_N)
        (seen_powerup && !COND.fatal && !COND.noncritical && BOOT_STAGE == SLED_BOOT_OS)
        |=> !HEALTH_LED.amber && HEALTH_LED.green == $past(ph_1hz))
        else $error("os boot not blinking green");
    chk_alarm_phase: assert property (@(posedge CORE_CLK) disable iff (!RST_N)
        (seen_powerup && !COND.fatal && COND.noncritical) |=> HEALTH_LED.amber == $past(ph_1hz))
        else $error("alarm not blinking amber");
endmodule : sled_ctrl

// file: hdl/sled_pkg.sv
// Package for the status and identification LED controller
package sled_pkg;
    localparam int unsigned CLK_HZ        = 125000000;
    localparam int unsigned HEALTH_BLINK_HZ = 1;
    localparam int unsigned ID_FAST_HZ    = 3;
    localparam int unsigned ID_SLOW_HZ    = 1;
    // Half periods in clock cycles, rounded down
    localparam int unsigned HALF_1HZ_CYC  = CLK_HZ / (2 * HEALTH_BLINK_HZ);
    localparam int unsigned HALF_3HZ_CYC  = CLK_HZ / (2 * ID_FAST_HZ);
    localparam int unsigned HALF_ID_CYC   = CLK_HZ / (2 * ID_SLOW_HZ);
    localparam int unsigned CNT_W         = 27;

    // Health display, least severe first
    typedef enum logic [1:0] {
        SLED_SOLID_GREEN,
        SLED_BLINK_GREEN,
        SLED_BLINK_AMBER,
        SLED_SOLID_AMBER
    } sled_health_t;

    // Controller boot progress reported by management firmware
    typedef enum logic [1:0] {
        SLED_BOOT_POWERUP,
        SLED_BOOT_LOADER,
        SLED_BOOT_OS,
        SLED_BOOT_DONE
    } sled_boot_t;

    typedef struct packed {
        logic green;
        logic amber;
    } sled_bicolor_t;

    // Reported system conditions, one bit each
    typedef struct packed {
        logic fatal;        // Catastrophic error, thermal trip, missing CPU, power fault, UE
        logic noncritical;  // Critical threshold or regulator overheat
        logic degraded;     // Redundancy loss, fan warning, predictive fail, battery
        logic wdt_reset;    // Controller reset by watchdog
        logic pu_cfg_err;   // Power unit configuration error offset
        logic hsc_degraded; // Drive hot-swap controller off-line or degraded
    } sled_cond_t;
endpackage : sled_pkg

// file: verif/sled_panel.sv
// Front-panel model: identify button driven by a person
`timescale 1ns/1ps
module sled_panel (
    input  wire logic clk,   // Core clock
    input  wire logic press, // Request one button press
    output logic      btn    // Button level, high pressed
);
    // Held for three cycles so the design must ignore a long press
    logic [1:0] hold = 2'h0;
    always_ff @(posedge clk) begin
        if (press) begin
            hold <= 2'h3;
        end else if (hold != 2'h0) begin
            hold <= hold - 2'h1;
        end
    end
    assign btn = (hold != 2'h0);
endmodule : sled_panel

// file: verif/tb_top.sv
// Self-checking bench for the status and identification LED controller
`timescale 1ns/1ps
module tb_top;
    import sled_pkg::*;
    typedef struct packed {
        sled_boot_t    boot;
        logic          err;
        sled_cond_t    cond;
        logic          id;
        sled_bicolor_t hl;
        sled_health_t  st;
    } sled_row_t;
    logic          clk, rst_n, r_on, r_off, berr, press, btn, id_led, fp_id;
    sled_boot_t    stage;
    sled_cond_t    cond;
    sled_bicolor_t hl, fp_hl;
    int            fail_count = 0;
    int            n_compared = 0;
    // Blink phases stay off for the whole run, so blinking shows dark;
    // the chosen display state is therefore compared as well
    sled_row_t rows [10] = '{
        '{SLED_BOOT_DONE, 1'b0, 6'h00, 1'b0, 2'h2, SLED_SOLID_GREEN},
        '{SLED_BOOT_LOADER, 1'b0, 6'h00, 1'b0, 2'h0, SLED_BLINK_GREEN},
        '{SLED_BOOT_OS, 1'b0, 6'h00, 1'b1, 2'h0, SLED_BLINK_GREEN},
        '{SLED_BOOT_DONE, 1'b1, 6'h00, 1'b0, 2'h0, SLED_BLINK_GREEN},
        '{SLED_BOOT_DONE, 1'b0, 6'h08, 1'b0, 2'h0, SLED_BLINK_GREEN},
        '{SLED_BOOT_DONE, 1'b0, 6'h04, 1'b0, 2'h0, SLED_BLINK_GREEN},
        '{SLED_BOOT_DONE, 1'b0, 6'h03, 1'b0, 2'h0, SLED_BLINK_GREEN},
        '{SLED_BOOT_DONE, 1'b0, 6'h10, 1'b0, 2'h0, SLED_BLINK_AMBER},
        '{SLED_BOOT_DONE, 1'b0, 6'h20, 1'b0, 2'h1, SLED_SOLID_AMBER},
        '{SLED_BOOT_OS, 1'b1, 6'h3f, 1'b1, 2'h1, SLED_SOLID_AMBER}
    };
    sled_ctrl uut (.CORE_CLK(clk), .RST_N(rst_n), .ID_BUTTON(btn), .ID_REMOTE_ON(r_on),
                   .ID_REMOTE_OFF(r_off), .BOOT_STAGE(stage), .BOOT_ERROR(berr), .COND(cond),
                   .ID_LED(id_led), .FP_ID_LED(fp_id), .HEALTH_LED(hl), .FP_HEALTH_LED(fp_hl));
    sled_panel panel (.clk(clk), .press(press), .btn(btn));
    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end
    task automatic check(input logic [7:0] seen, input logic [7:0] want);
        n_compared++;
        if (seen !== want) begin
            fail_count++;
            $display("CHECK FAILED t=%0t seen=%h want=%h", $time, seen, want);
        end
    endtask : check
    task automatic expect_leds(input logic id, input sled_bicolor_t h);
        check({7'h00, id_led}, {7'h00, id});
        check({6'h00, hl}, {6'h00, h});
        check({7'h00, fp_id}, {7'h00, id});
        check({6'h00, fp_hl}, {6'h00, h});
    endtask : expect_leds
    task automatic settle(input int n);
        repeat (n) @(posedge clk);
        @(negedge clk);
    endtask : settle
    task automatic report_and_stop;
        $display("compared %0d, mismatches %0d", n_compared, fail_count);
        if (fail_count == 0 && n_compared > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask : report_and_stop
    task automatic push;
        @(posedge clk) press <= 1'b1;
        @(posedge clk) press <= 1'b0;
        settle(6);
    endtask : push
    initial begin
        #400000;
        fail_count++;
        report_and_stop();
    end
    initial begin
        {rst_n, r_on, r_off, berr, press} = 5'h00;
        stage = SLED_BOOT_POWERUP;
        cond  = 6'h00;
        repeat (12) @(posedge clk);
        @(negedge clk);
        expect_leds(1'b0, 2'h1);
        @(posedge clk) rst_n <= 1'b1;
        settle(1);
        expect_leds(1'b0, 2'h1);
        settle(1);
        expect_leds(1'b0, 2'h0);
        $display("test reset done");
        foreach (rows[i]) begin
            @(posedge clk);
            stage <= rows[i].boot;
            berr  <= rows[i].err;
            cond  <= rows[i].cond;
            settle(2);
            expect_leds(rows[i].id, rows[i].hl);
            check({6'h00, uut.next_health}, {6'h00, rows[i].st});
        end
        $display("test table done");
        @(posedge clk);
        stage <= SLED_BOOT_DONE;
        berr  <= 1'b0;
        cond  <= 6'h00;
        push();
        expect_leds(1'b1, 2'h2);
        push();
        expect_leds(1'b0, 2'h2);
        push();
        $display("test button done");
        @(posedge clk) r_on <= 1'b1;
        @(posedge clk) r_on <= 1'b0;
        settle(2);
        expect_leds(1'b0, 2'h2);
        @(posedge clk) {r_on, r_off} <= 2'h3;
        @(posedge clk) {r_on, r_off} <= 2'h0;
        settle(2);
        expect_leds(1'b0, 2'h2);
        @(posedge clk) r_off <= 1'b1;
        @(posedge clk) r_off <= 1'b0;
        settle(2);
        expect_leds(1'b1, 2'h2);
        $display("test remote done");
        // Mid-run reset must clear the identify state and replay the amber cycle
        @(posedge clk) rst_n <= 1'b0;
        settle(1);
        expect_leds(1'b0, 2'h1);
        @(posedge clk) rst_n <= 1'b1;
        settle(1);
        expect_leds(1'b0, 2'h1);
        settle(1);
        expect_leds(1'b0, 2'h2);
        $display("test second reset done");
        report_and_stop();
    end
endmodule : tb_top
